// ### bldf_top.sv
// forwarding decisions and control register of a pcie to pci bridge
// Behaviour
// - full-decode bit enables io bits 15:10 compare
// - display enable claims A0000-BFFFF memory downstream
// - display enable forwards 3B0-3BB, 3C0-3DF io
// - display addresses from secondary are not forwarded
// - display forwarding ignores filter and windows
// - io/memory space enables qualify display forwarding
// - display disabled: forward downstream only inside windows
// - alias filter only inside io window, 64k
// - filter blocks top 768 down, forwards up
// - filter cleared forwards whole io window
// - syserr forwarded when enable, cmd bit8, serr
// - parity enable gates secondary error reporting
// - data error always poisons upstream data
// - control bits reset to zero
// - secondary reset follows reset bit
`timescale 1ns/1ps
`include "bldf_cfg.svh"

module bldf_top (
    // clock and reset
    input  wire logic              sys_clk_in,
    input  wire logic              reset_in,
    // configuration access to the control register
    input  wire logic              cfg_wr_in,
    input  wire logic [1:0]        cfg_be_in,
    input  wire logic [15:0]       cfg_wdata_in,
    output logic      [15:0]       cfg_rdata_out,
    // command register bits and programmed windows
    input  wire logic [15:0]       cmd_in,
    input  wire logic              io_win_hit_in,
    input  wire logic              mem_win_hit_in,
    // transaction to decode
    input  wire bldf_pkg::bldf_req_t req_in,
    output bldf_pkg::bldf_dec_t    dec_out,
    // secondary bus events
    input  wire logic              sec_serr_in,
    input  wire bldf_pkg::bldf_err_t sec_err_in,
    output logic                   syserr_fwd_out,
    output bldf_pkg::bldf_err_t    err_report_out,
    output logic                   poison_out,
    output logic                   secondary_reset_output_out
);
    import bldf_pkg::*;

    logic [15:0] bridge_forwarding_control;
    logic [15:0] next_ctrl;
    bldf_dec_t   next_dec;

    // byte lanes; only the low byte holds writable bits here
    assign next_ctrl = {cfg_be_in[1] ? cfg_wdata_in[15:8] : bridge_forwarding_control[15:8],
                        cfg_be_in[0] ? cfg_wdata_in[7:0]  : bridge_forwarding_control[7:0]}
                       & `BLDF_RW_MASK;

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            bridge_forwarding_control <= `BLDF_CTRL_RESET;
        end else if (cfg_wr_in) begin
            bridge_forwarding_control <= next_ctrl;
        end
    end

    assign cfg_rdata_out = bridge_forwarding_control;

    wire full_decode = bridge_forwarding_control[`BLDF_BIT_FULL_DECODE];
    wire disp_en     = bridge_forwarding_control[`BLDF_BIT_DISP_EN];
    wire exp_filter  = bridge_forwarding_control[`BLDF_BIT_EXP_FILTER];
    wire syserr_en   = bridge_forwarding_control[`BLDF_BIT_SYSERR_FWD];
    wire parity_en   = bridge_forwarding_control[`BLDF_BIT_PARITY_RESP];
    wire io_space_enable       = cmd_in[`BLDF_CMD_IO_BIT];
    wire memory_space_enable   = cmd_in[`BLDF_CMD_MEM_BIT];
    wire primary_syserr_enable = cmd_in[`BLDF_CMD_SERR_BIT];

    wire [9:0] io_lo = req_in.addr[9:0];
    wire in_low_64k  = (req_in.addr[31:16] == `BLDF_IO_64K_TOP);
    // without full decode, bits 15:10 are don't-care so every alias matches
    wire io_hi_ok    = !full_decode || (req_in.addr[15:10] == `BLDF_IO_HI_ZERO);
    wire disp_io_lo  = ((io_lo >= `BLDF_DISP_IO_A_LO) && (io_lo <= `BLDF_DISP_IO_A_HI)) ||
                       ((io_lo >= `BLDF_DISP_IO_B_LO) && (io_lo <= `BLDF_DISP_IO_B_HI));
    wire disp_io     = !req_in.is_io ? 1'b0 : (in_low_64k && io_hi_ok && disp_io_lo);
    wire disp_mem    = !req_in.is_io && (req_in.addr >= `BLDF_DISP_MEM_LO) &&
                       (req_in.addr <= `BLDF_DISP_MEM_HI);
    wire disp_hit    = disp_en && (disp_io || disp_mem);
    // enables from the command register gate display forwarding
    wire disp_fwd    = disp_en && ((disp_io && io_space_enable) ||
                                   (disp_mem && memory_space_enable));
    // top 768 bytes of each 1k block are the alias region
    wire alias_hit   = req_in.is_io && io_win_hit_in && in_low_64k &&
                       (io_lo >= `BLDF_ALIAS_LO_LIMIT);
    wire filt_block  = exp_filter && alias_hit;
    wire win_hit     = req_in.is_io ? (io_win_hit_in && io_space_enable)
                                    : (mem_win_hit_in && memory_space_enable);

    always_comb begin
        next_dec = '0;
        if (req_in.valid) begin
            if (!req_in.upstream) begin
                if (disp_hit) begin
                    next_dec.fwd = disp_fwd;
                end else begin
                    next_dec.fwd   = win_hit && !filt_block;
                    next_dec.block = filt_block;
                end
            end else begin
                // upstream: outside the window goes to primary, alias region too when the filter is set
                next_dec.fwd   = !disp_hit && (!win_hit || (exp_filter && alias_hit));
                next_dec.block = disp_hit;
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            dec_out                    <= '0;
            syserr_fwd_out             <= 1'b0;
            err_report_out             <= '0;
            poison_out                 <= 1'b0;
            secondary_reset_output_out <= 1'b0;
        end else begin
            dec_out        <= next_dec;
            syserr_fwd_out <= syserr_en && primary_syserr_enable && sec_serr_in;
            err_report_out <= parity_en ? sec_err_in : '0;
            poison_out     <= sec_err_in.data_err;
            secondary_reset_output_out <= bridge_forwarding_control[`BLDF_BIT_SEC_RESET];
        end
    end
endmodule : bldf_top

// ### bldf_cfg.svh
// constants for the bridge legacy decode and error forwarding block
`ifndef BLDF_CFG_SVH
`define BLDF_CFG_SVH
`define BLDF_BIT_PARITY_RESP    0
`define BLDF_BIT_SYSERR_FWD     1
`define BLDF_BIT_EXP_FILTER     2
`define BLDF_BIT_DISP_EN        3
`define BLDF_BIT_FULL_DECODE    4
`define BLDF_BIT_MASTER_ABORT   5
`define BLDF_BIT_SEC_RESET      6
`define BLDF_BIT_FAST_B2B       7
`define BLDF_RW_MASK            16'h00FF
`define BLDF_CTRL_RESET         16'h0000
`define BLDF_CMD_IO_BIT         0
`define BLDF_CMD_MEM_BIT        1
`define BLDF_CMD_SERR_BIT       8
`define BLDF_DISP_MEM_LO        32'h000A0000
`define BLDF_DISP_MEM_HI        32'h000BFFFF
`define BLDF_DISP_IO_A_LO       10'h3B0
`define BLDF_DISP_IO_A_HI       10'h3BB
`define BLDF_DISP_IO_B_LO       10'h3C0
`define BLDF_DISP_IO_B_HI       10'h3DF
`define BLDF_IO_64K_TOP         16'h0000
`define BLDF_IO_HI_ZERO         6'h00
`define BLDF_ALIAS_LO_LIMIT     10'h100
`endif

// ### bldf_pkg.sv
// types for the bridge legacy decode and error forwarding block
package bldf_pkg;
    typedef struct packed {
        logic        valid;
        logic        is_io;
        logic        upstream;
        logic [31:0] addr;
    } bldf_req_t;

    typedef struct packed {
        logic        fwd;
        logic        block;
    } bldf_dec_t;

    typedef struct packed {
        logic        addr_err;
        logic        attr_err;
        logic        data_err;
    } bldf_err_t;
endpackage : bldf_pkg

// ### bldf_chk.sv
// port assertions for the bridge decode block
`timescale 1ns/1ps
module bldf_chk (
    input wire logic                sys_clk_in, reset_in, cfg_wr_in, sec_serr_in,
    input wire logic                poison_out, syserr_fwd_out, secondary_reset_output_out,
    input wire logic [1:0]          cfg_be_in,
    input wire logic [15:0]         cfg_wdata_in, cfg_rdata_out, cmd_in,
    input wire bldf_pkg::bldf_req_t req_in,
    input wire bldf_pkg::bldf_dec_t dec_out,
    input wire bldf_pkg::bldf_err_t sec_err_in, err_report_out
);
    import bldf_pkg::*;
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (reset_in);
    wire dm = req_in.valid && !req_in.is_io && cfg_rdata_out[3]
        && req_in.addr >= 32'h000A0000 && req_in.addr <= 32'h000BFFFF;
    property p_rst; $past(reset_in) |-> cfg_rdata_out == 16'h0000; endproperty
    a_rst: assert property (p_rst) else $error("control not clear");
    property p_wr; cfg_wr_in && cfg_be_in[0] |=> cfg_rdata_out[7:0] == $past(cfg_wdata_in[7:0])
        && cfg_rdata_out[15:8] == 8'h00; endproperty
    a_wr: assert property (p_wr) else $error("readback wrong");
    property p_dn; dm && !req_in.upstream && cmd_in[1] |=> dec_out.fwd; endproperty
    a_dn: assert property (p_dn) else $error("display memory not claimed");
    property p_up; dm && req_in.upstream |=> !dec_out.fwd; endproperty
    a_up: assert property (p_up) else $error("display memory forwarded up");
    property p_secondary_bus_reset_bit; cfg_rdata_out[6] [*2] |-> secondary_reset_output_out; endproperty
    a_secondary_bus_reset_bit: assert property (p_secondary_bus_reset_bit) else $error("secondary reset low");
    property p_serr; !$past(reset_in) |-> syserr_fwd_out == ($past(cfg_rdata_out[1])
        && $past(cmd_in[8]) && $past(sec_serr_in)); endproperty
    a_serr: assert property (p_serr) else $error("syserr forward wrong");
    property p_err; !$past(reset_in) |-> err_report_out
        == ($past(sec_err_in) & {3{$past(cfg_rdata_out[0])}}); endproperty
    a_err: assert property (p_err) else $error("error report wrong");
    property p_psn; sec_err_in.data_err |=> poison_out; endproperty
    a_psn: assert property (p_psn) else $error("poison missing");
endmodule : bldf_chk
bind bldf_top bldf_chk bldf_chk_inst (.*);

// ### bldf_sec_mdl.sv
// secondary bus event source
`timescale 1ns/1ps
module bldf_sec_mdl (
    input wire logic [3:0]       ev_in,
    output logic                 serr_out,
    output bldf_pkg::bldf_err_t  err_out
);
    // events are levels set by the bench off the sampling edge
    assign {serr_out, err_out} = ev_in;
endmodule : bldf_sec_mdl

// ### tb_bldf_top.sv
// self-checking bench for the bridge decode block
`timescale 1ns/1ps
module tb_bldf_top;
    import bldf_pkg::*;
    logic sys_clk_in = 0, reset_in = 1, cfg_wr_in = 0, io_win_hit_in = 0, mem_win_hit_in = 0;
    logic [1:0] cfg_be_in = 2'h3;
    logic [15:0] cfg_wdata_in = 16'h0000, cmd_in = 16'h0000, cfg_rdata_out;
    logic [3:0] ev = 4'h0;
    logic sec_serr_in, syserr_fwd_out, poison_out, secondary_reset_output_out;
    bldf_req_t req_in = '0;
    bldf_dec_t dec_out;
    bldf_err_t sec_err_in, err_report_out;
    int err_total = 0, compares = 0;
    bldf_top bldf_top_inst (.*);
    bldf_sec_mdl bldf_sec_mdl_inst (.ev_in(ev), .serr_out(sec_serr_in), .err_out(sec_err_in));
    always #2 sys_clk_in = ~sys_clk_in;
    task chk(string n, logic [15:0] e, logic [15:0] g);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task wr(logic [15:0] v);
        @(negedge sys_clk_in) {cfg_wr_in, cfg_wdata_in} = {1'b1, v};
        @(negedge sys_clk_in) cfg_wr_in = 0;
    endtask : wr
    task dq(logic io, logic up, logic [31:0] a, logic e);
        @(negedge sys_clk_in) req_in = '{1'b1, io, up, a};
        @(negedge sys_clk_in) req_in.valid = 0;
        chk("fwd", {15'h0, e}, {15'h0, dec_out.fwd});
    endtask : dq
    task evt(logic [3:0] v, logic [4:0] e);
        @(negedge sys_clk_in) ev = v;
        @(negedge sys_clk_in) ev = 0;
        chk("events", {11'h0, e}, {11'h0, syserr_fwd_out, err_report_out, poison_out});
    endtask : evt
    task t_reg;
        chk("ctrl", 16'h0000, cfg_rdata_out);
        wr(16'hFFFF);
        chk("ctrl", 16'h00FF, cfg_rdata_out);
        @(negedge sys_clk_in);
        chk("secondary_bus_reset_bit", 16'h0001, {15'h0, secondary_reset_output_out});
    endtask : t_reg
    task t_disp;
        cmd_in = 16'h0003;
        wr(16'h0008);
        dq(0, 0, 32'h000BFFFF, 1);
        dq(0, 0, 32'h000C0000, 0);
        dq(0, 1, 32'h000A0000, 0);
        dq(1, 0, 32'h000007C0, 1);
        dq(1, 0, 32'h000003BC, 0);
        cmd_in = 16'h0000;
        dq(0, 0, 32'h000A0000, 0);
        cmd_in = 16'h0003;
        wr(16'h0018);
        dq(1, 0, 32'h000007C0, 0);
    endtask : t_disp
    task t_filt;
        io_win_hit_in = 1;
        wr(16'h0004);
        dq(1, 0, 32'h00000500, 0);
        chk("block", 16'h0001, {15'h0, dec_out.block});
        dq(1, 0, 32'h000004C0, 1);
        dq(1, 1, 32'h00000500, 1);
        dq(1, 0, 32'h00010500, 1);
        wr(16'h000C);
        dq(1, 0, 32'h000003C0, 1);
        wr(16'h0000);
        dq(1, 0, 32'h00000500, 1);
        dq(1, 0, 32'h000003C0, 1);
    endtask : t_filt
    task t_evt;
        cmd_in = 16'h0103;
        wr(16'h0003);
        evt(4'b1000, 5'b10000);
        evt(4'b0111, 5'b01111);
        wr(16'h0000);
        evt(4'b1001, 5'b00001);
    endtask : t_evt
    task complete_run;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : complete_run
    initial begin
        repeat (5) @(negedge sys_clk_in);
        reset_in = 0;
        t_reg();
        t_disp();
        t_filt();
        t_evt();
        complete_run();
    end
    // about 56 cycles of traffic, generous margin
    initial begin
        #4000;
        err_total++;
        complete_run();
    end
endmodule : tb_bldf_top
